// ---- core/adcs_seq.sv ----
// conversion sequencer with channel selection and an axi4-lite register slave
module adcs_seq #(
	parameter int RESULT_W = 10,
	parameter int SLOTS = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic conv_start,
	output adcs_pkg::adcs_source_t conv_source,
	input wire logic conv_done,
	input wire logic [RESULT_W-1:0] conv_result
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (SLOTS != 8) begin : g_bad_slots
		$error("SLOTS must be 8");
	end
	if (RESULT_W < 1 || RESULT_W > 16) begin : g_bad_width
		$error("RESULT_W must be 1 to 16");
	end

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ISSUE,
		SEQ_WAIT
	} adcs_seq_state_t;

	typedef struct packed {
		adcs_pkg::adcs_ctrl_t ctrl;
		logic enable;
		adcs_seq_state_t seq;
		logic [2:0] step;
		logic discard;
		logic pending;
		logic seq_done;
		logic [SLOTS-1:0] conv_flags;
		logic [SLOTS-1:0][RESULT_W-1:0] results;
		logic start;
		adcs_pkg::adcs_source_t source;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} adcs_state_t;

	adcs_state_t state_reg;
	adcs_state_t state_next;
	logic [3:0] code_now;
	adcs_pkg::adcs_source_t source_now;
	logic [3:0] seq_len;
	logic [2:0] slot_now;
	logic ctrl_write;
	localparam int RESULT_IDX_W_L = adcs_pkg::RESULT_IDX_W;
	logic [RESULT_IDX_W_L-1:0] rd_idx;

	// ----------------------------------------
	// channel and slot selection
	// ----------------------------------------
	always_comb begin
		if (state_reg.ctrl.length_msb) begin
			seq_len = adcs_pkg::LEN_EIGHT;
		end else if (state_reg.ctrl.length_lsb) begin
			seq_len = adcs_pkg::LEN_ONE;
		end else begin
			seq_len = adcs_pkg::LEN_FOUR;
		end
		slot_now = state_reg.step;
		if (!state_reg.ctrl.multichannel_enable) begin
			// software owns all four bits here
			code_now = state_reg.ctrl.chan_sel;
		end else if (state_reg.ctrl.length_msb) begin
			code_now = {state_reg.ctrl.chan_sel[3], state_reg.step};
		end else begin
			code_now = {state_reg.ctrl.chan_sel[3:2], state_reg.step[1:0]};
		end
	end

	adcs_decode u_decode (
		.code(code_now),
		.source(source_now)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.start = 1'b0;
		ctrl_write = 1'b0;
		rd_idx = s_axi_araddr[adcs_pkg::RESULT_IDX_LSB +: RESULT_IDX_W_L];

		// address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready) begin
			state_next.aw_got = 1'b1;
			state_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_next.w_got = 1'b1;
			state_next.wdata = s_axi_wdata;
			state_next.wstrb = s_axi_wstrb;
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = adcs_pkg::RESP_OKAY;
			case (state_reg.awaddr)
				adcs_pkg::ADDR_CTRL: begin
					if (state_reg.wstrb[0]) begin
						state_next.ctrl = state_reg.wdata[adcs_pkg::CTRL_W-1:0];
						ctrl_write = 1'b1;
					end
				end
				adcs_pkg::ADDR_ENABLE: begin
					if (state_reg.wstrb[0]) begin
						state_next.enable = state_reg.wdata[0];
					end
				end
				adcs_pkg::ADDR_STATUS: begin
				end
				default: begin
					if (state_reg.awaddr < adcs_pkg::ADDR_RESULT_BASE
							|| state_reg.awaddr > adcs_pkg::ADDR_RESULT_LAST
							|| state_reg.awaddr[1:0] != 2'h0) begin
						state_next.bresp = adcs_pkg::RESP_SLVERR;
					end
				end
			endcase
		end

		// read channel
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = adcs_pkg::RESP_OKAY;
			state_next.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				adcs_pkg::ADDR_CTRL: begin
					state_next.rdata[adcs_pkg::CTRL_W-1:0] = state_reg.ctrl;
				end
				adcs_pkg::ADDR_ENABLE: begin
					state_next.rdata[0] = state_reg.enable;
				end
				adcs_pkg::ADDR_STATUS: begin
					state_next.rdata[adcs_pkg::ST_FLAGS_LSB +: SLOTS] = state_reg.conv_flags;
					state_next.rdata[adcs_pkg::ST_COUNT_LSB +: 3] = state_reg.step;
					state_next.rdata[adcs_pkg::ST_SEQ_DONE_BIT] = state_reg.seq_done;
					state_next.rdata[adcs_pkg::ST_BUSY_BIT] = state_reg.seq != SEQ_IDLE;
				end
				default: begin
					if (s_axi_araddr >= adcs_pkg::ADDR_RESULT_BASE
							&& s_axi_araddr <= adcs_pkg::ADDR_RESULT_LAST
							&& s_axi_araddr[1:0] == 2'h0) begin
						state_next.rdata[RESULT_W-1:0] = state_reg.results[rd_idx];
					end else begin
						state_next.rresp = adcs_pkg::RESP_SLVERR;
					end
				end
			endcase
		end

		// sequencer
		case (state_reg.seq)
			SEQ_IDLE: begin
			end
			SEQ_ISSUE: begin
				state_next.start = 1'b1;
				state_next.source = source_now;
				state_next.seq = SEQ_WAIT;
			end
			SEQ_WAIT: begin
				if (conv_done && state_reg.discard) begin
					// the aborted conversion has drained; launch what is pending
					state_next.discard = 1'b0;
					state_next.seq = state_reg.pending ? SEQ_ISSUE : SEQ_IDLE;
				end else if (conv_done) begin
					state_next.results[slot_now] = conv_result;
					state_next.conv_flags[slot_now] = 1'b1;
					if ({1'b0, state_reg.step} == seq_len - 4'h1) begin
						// set again at each sequence end, scan included
						state_next.seq_done = 1'b1;
						state_next.step = 3'h0;
						if (state_reg.ctrl.scan) begin
							state_next.seq = SEQ_ISSUE;
						end else begin
							state_next.seq = SEQ_IDLE;
							state_next.pending = 1'b0;
						end
					end else begin
						state_next.step = state_reg.step + 3'h1;
						state_next.seq = SEQ_ISSUE;
					end
				end
			end
			default: begin
				state_next.seq = SEQ_IDLE;
			end
		endcase

		// disabling stops any run, a scan included
		if (!state_next.enable) begin
			state_next.pending = 1'b0;
			// a launched conversion is drained, never cut short
			if (state_next.seq == SEQ_WAIT && !(conv_done && state_reg.seq == SEQ_WAIT)) begin
				state_next.discard = 1'b1;
			end else if (state_next.seq != SEQ_WAIT) begin
				state_next.seq = SEQ_IDLE;
			end
		end

		// a control write restarts from slot zero; it wins over any flag set
		if (ctrl_write) begin
			state_next.seq_done = 1'b0;
			state_next.conv_flags = '0;
			state_next.step = 3'h0;
			state_next.pending = state_next.enable;
			if (state_reg.seq == SEQ_WAIT && !conv_done) begin
				// converter still busy: drop its answer, then start over
				state_next.discard = 1'b1;
				state_next.seq = SEQ_WAIT;
			end else begin
				// a launch staged for this edge is withdrawn, so no second
				// conversion goes out while the first is still in flight
				state_next.start = 1'b0;
				state_next.source = state_reg.source;
				state_next.discard = 1'b0;
				state_next.seq = state_next.enable ? SEQ_ISSUE : SEQ_IDLE;
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			// results start at zero so early reads return a defined value
			state_reg <= '0;
			state_reg.ctrl <= adcs_pkg::CTRL_RESET;
			state_reg.seq <= SEQ_IDLE;
			state_reg.source.kind <= adcs_pkg::SRC_EXTERNAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// ready stays low while a response waits: one write at a time
	assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
	assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign conv_start = state_reg.start;
	assign conv_source = state_reg.source;

endmodule : adcs_seq

// ---- core/adcs_pkg.sv ----
// shared constants and types of the conversion sequence controller
package adcs_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ENABLE = 8'h08;
	localparam logic [7:0] ADDR_RESULT_BASE = 8'h20;
	localparam logic [7:0] ADDR_RESULT_LAST = 8'h3c;
	localparam int RESULT_IDX_LSB = 2;
	localparam int RESULT_IDX_W = 3;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CTRL_W = 8;
	localparam int BIT_LENGTH_LSB = 7;
	localparam int BIT_LENGTH_MSB = 6;
	localparam int BIT_SCAN = 5;
	localparam int BIT_MULTICHANNEL = 4;
	localparam int CHAN_SEL_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------
	// status register fields
	// ----------------------------------------
	localparam int ST_FLAGS_LSB = 0;
	localparam int ST_COUNT_LSB = 8;
	localparam int ST_SEQ_DONE_BIT = 15;
	localparam int ST_BUSY_BIT = 16;

	// ----------------------------------------
	// sequence lengths and codes
	// ----------------------------------------
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [3:0] LEN_FOUR = 4'h4;
	localparam logic [3:0] LEN_EIGHT = 4'h8;
	localparam logic [3:0] CODE_RESV_FIRST = 4'h8;
	localparam logic [3:0] CODE_REF_HIGH = 4'hc;
	localparam logic [3:0] CODE_REF_LOW = 4'hd;
	localparam logic [3:0] CODE_REF_MID = 4'he;
	localparam logic [3:0] CODE_TEST = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_EXTERNAL,
		SRC_RESERVED,
		SRC_REF_HIGH,
		SRC_REF_LOW,
		SRC_REF_MID,
		SRC_TEST
	} adcs_src_kind_t;

	// analog source handed to the converter
	typedef struct packed {
		adcs_src_kind_t kind;
		logic [2:0] index;
		logic [3:0] code;
	} adcs_source_t;

	// control register contents
	typedef struct packed {
		logic length_lsb;
		logic length_msb;
		logic scan;
		logic multichannel_enable;
		logic [3:0] chan_sel;
	} adcs_ctrl_t;

endpackage : adcs_pkg

// ---- core/adcs_decode.sv ----
// decode of a four-bit channel code into an analog source
module adcs_decode (
	input wire logic [3:0] code,
	output adcs_pkg::adcs_source_t source
);

	always_comb begin
		source.code = code;
		source.index = code[2:0];
		if (code < adcs_pkg::CODE_RESV_FIRST) begin
			source.kind = adcs_pkg::SRC_EXTERNAL;
		end else if (code == adcs_pkg::CODE_REF_HIGH) begin
			source.kind = adcs_pkg::SRC_REF_HIGH;
		end else if (code == adcs_pkg::CODE_REF_LOW) begin
			source.kind = adcs_pkg::SRC_REF_LOW;
		end else if (code == adcs_pkg::CODE_REF_MID) begin
			source.kind = adcs_pkg::SRC_REF_MID;
		end else if (code == adcs_pkg::CODE_TEST) begin
			source.kind = adcs_pkg::SRC_TEST;
		end else begin
			// still converted, result carries no meaning
			source.kind = adcs_pkg::SRC_RESERVED;
		end
	end

endmodule : adcs_decode

// ---- test/adcs_seq_asserts.sv ----
// port checker of the conversion sequencer
module adcs_seq_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic conv_start,
	input wire adcs_pkg::adcs_source_t conv_source,
	input wire logic conv_done
);
	// ----
	// conversion in flight
	// ----
	logic busy_reg;
	always_ff @(posedge clk) begin
		if (!resetn) busy_reg <= 1'b0;
		else if (conv_start) busy_reg <= 1'b1;
		else if (conv_done) busy_reg <= 1'b0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// a start is followed by at least two quiet cycles
	sequence s_gap;
		!conv_start [*2];
	endsequence
	chk_start_pulse: assert property (conv_start |=> s_gap)
		else $error("start pulses too close");
	chk_one_flight: assert property (conv_start |-> !busy_reg)
		else $error("start while a conversion is outstanding");
	chk_source_hold: assert property (!conv_start |-> $stable(conv_source))
		else $error("source moved without a start");
	chk_ext_decode: assert property (conv_start && !conv_source.code[3] |->
		conv_source.kind == adcs_pkg::SRC_EXTERNAL && conv_source.index == conv_source.code[2:0])
		else $error("external code decoded wrongly");
	chk_resv_decode: assert property (conv_start && conv_source.code[3:2] == 2'b10 |->
		conv_source.kind == adcs_pkg::SRC_RESERVED)
		else $error("reserved code decoded wrongly");
	chk_ref_decode: assert property (conv_start && &conv_source.code[3:2] |->
		conv_source.kind == 3'(conv_source.code[1:0]) + 3'h2)
		else $error("reference code decoded wrongly");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule : adcs_seq_asserts

// ---- test/adcs_seq_tb.sv ----
// self-checking bench of the conversion sequencer
module adcs_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, resetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, conv_done = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_start;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [9:0] conv_result = 10'h000, v;
	adcs_pkg::adcs_source_t conv_source;
	adcs_pkg::adcs_source_t got[$];
	logic [9:0] res[$];
	int seed = 32'h4f3d, err_total = 0, compares = 0, cyc = 0, dly = 0;
	logic [1:0] bresp_seen = 2'h0;
	logic [7:0] cor[9] = '{8'h13, 8'h14, 8'h1a, 8'h1f, 8'h50, 8'h5f, 8'h0d, 8'h83, 8'h9e};
	adcs_seq dut_u (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .conv_start, .conv_source, .conv_done, .conv_result);
	initial begin
		forever #5 clk = ~clk;
	end
	task print_verdict;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// ----
	// converter stand-in, slow on purpose: 3 to 6 cycles a conversion
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		conv_done <= 1'b0;
		if (dly > 0) dly <= dly - 1;
		if (dly == 1) begin
			v = 10'($random(seed));
			conv_done <= 1'b1;
			conv_result <= v;
			res.push_back(v);
		end
		if (conv_start) begin
			got.push_back(conv_source);
			dly <= 3 + ($random(seed) & 3);
		end
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	// ----
	// expectations and bus tasks
	// ----
	function automatic int elen(logic [7:0] c);
		return c[6] ? 8 : (c[7] ? 1 : 4);
	endfunction : elen
	function automatic logic [9:0] esrc(logic [7:0] c, int k);
		logic [3:0] e;
		logic [2:0] kd;
		e = !c[4] ? c[3:0] : c[6] ? {c[3], 3'(k)} : {c[3:2], 2'(k)};
		kd = !e[3] ? 3'h0 : !e[2] ? 3'h1 : 3'(e[1:0]) + 3'h2;
		return {kd, e[2:0], e};
	endfunction : esrc
	task automatic chk(logic [31:0] g, logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// ready comes after a random lag and then holds, so the hold checks see stalls
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int lag;
		logic bt;
		lag = $random(seed) & 3;
		bt = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		while (!bt) begin
			@(posedge clk);
			lag--;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			bt = s_axi_bvalid && s_axi_bready;
			if (bt) bresp_seen = s_axi_bresp;
			else if (lag == 0) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int lag;
		logic rt;
		lag = $random(seed) & 3;
		rt = 1'b0;
		d = 32'h0;
		r = 2'h0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		while (!rt) begin
			@(posedge clk);
			lag--;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			rt = s_axi_rvalid && s_axi_rready;
			if (rt) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
			end else if (lag == 0) begin
				s_axi_rready <= 1'b1;
			end
		end
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic run(logic [7:0] c);
		int n;
		logic [31:0] d;
		logic [1:0] r;
		n = elen(c);
		got.delete();
		res.delete();
		wr(8'h00, {24'h0, c});
		while (got.size() < n) @(posedge clk);
		repeat (20) @(posedge clk);
		chk(32'(got.size()), 32'(n));
		for (int k = 0; k < n; k++) begin
			chk(32'(got[k]), 32'(esrc(c, k)));
			rd(8'h20 + 8'(4 * k), d, r);
			chk(d, 32'(res[k]));
		end
		rd(8'h04, d, r);
		chk(32'({d[16:15], d[7:0]}), 32'({2'b01, 8'((1 << n) - 1)}));
	endtask : run
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] c;
		int n;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h00, d, r);
		chk(d, 32'(adcs_pkg::CTRL_RESET));
		rd(8'hf0, d, r);
		chk(32'(r), 32'(adcs_pkg::RESP_SLVERR));
		wr(8'hf0, 32'h0);
		chk(32'(bresp_seen), 32'(adcs_pkg::RESP_SLVERR));
		wr(8'h08, 32'h1);
		chk(32'(bresp_seen), 32'(adcs_pkg::RESP_OKAY));
		for (int i = 0; i < 15; i++) begin
			c = i < 9 ? cor[i] : 8'($random(seed));
			c[5] = 1'b0;
			run(c);
		end
		got.delete();
		wr(8'h00, 32'h34);
		while (got.size() < 9) @(posedge clk);
		for (int k = 0; k < 9; k++) chk(32'(got[k]), 32'(esrc(8'h34, k % 4)));
		rd(8'h04, d, r);
		chk(32'(d[15]), 32'h1);
		wr(8'h00, 32'h0c);
		rd(8'h04, d, r);
		chk(32'({d[15], d[7:0]}), 32'h0);
		repeat (40) @(posedge clk);
		chk(32'(got[$]), 32'(esrc(8'h0c, 0)));
		got.delete();
		wr(8'h00, 32'h24);
		while (got.size() < 3) @(posedge clk);
		chk(32'(got[0]), 32'(esrc(8'h24, 0)));
		wr(8'h08, 32'h0);
		repeat (20) @(posedge clk);
		n = got.size();
		repeat (60) @(posedge clk);
		chk(32'(got.size()), 32'(n));
		rd(8'h04, d, r);
		chk(32'(d[16]), 32'h0);
		wr(8'h00, 32'h13);
		repeat (30) @(posedge clk);
		chk(32'(got.size()), 32'(n));
		print_verdict();
	end
endmodule : adcs_seq_tb
bind adcs_seq adcs_seq_asserts chk_u (.clk, .resetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .conv_start, .conv_source, .conv_done);
